// *** hdl/augment_consts.svh ***
// constants for the page augment leaf unit: codes, checks, register map
// assumes inclusion by the unit alone, nothing else
`ifndef AUGMENT_CONSTS_SVH
`define AUGMENT_CONSTS_SVH
`define AUG_LEAF_CODE      32'h0000_000d
`define AUG_CPL_REQUIRED   2'h0
`define AUG_DESC_ALIGN_LSB 5
`define AUG_PAGE_LSB       12
`define AUG_PAGE_NUM_MSB   43
`define AUG_PT_REGULAR     8'h01
`define AUG_PT_CONTROL     8'h00
`define AUG_PAGE_WORDS     11'h400
`define AUG_WORD_BYTES     3'h4
`define AUG_OFF_CTRL       12'h000
`define AUG_OFF_CACHE_BASE 12'h004
`define AUG_OFF_CACHE_PGS  12'h008
`define AUG_OFF_STATUS     12'h00c
`define AUG_OFF_FAULT_LO   12'h010
`define AUG_OFF_FAULT_HI   12'h014
`define AUG_CTRL_RESET     32'h0000_0000
`define AUG_CTRL_ENABLE    0
`endif

// *** hdl/augment_pkg.sv ***
// types shared by the page augment leaf unit and its surroundings
// assumes 64-bit linear and physical addresses
package augment_pkg;
  typedef enum logic [1:0] {
    FAULT_NONE,
    FAULT_GP,
    FAULT_PF,
    FAULT_LEAF
  } fault_e;

  // one leaf issue from the pipeline, descriptor already fetched
  typedef struct packed {
    logic [31:0] accumulator_register;
    logic [1:0]  cpl;
    logic [63:0] second_operand_register;
    logic [63:0] third_operand_register;
    logic [63:0] control_page_ptr;
    logic [63:0] target_linear_address;
    logic [63:0] source_page_field;
    logic [63:0] security_info_field;
    logic        segment_violation;
    logic        operand_locked;
  } leaf_req_s;

  typedef struct packed {
    fault_e      kind;
    logic [63:0] addr;
  } leaf_rsp_s;

  // one protected page map entry
  typedef struct packed {
    logic        valid;
    logic        read_en;
    logic        write_en;
    logic        exec_en;
    logic [7:0]  page_type;
    logic        blocked;
    logic        pending;
    logic        flag_a;
    logic        permission_restrict_flag;
    logic [63:0] entry_linear_address;
    logic [63:0] control_id;
  } map_entry_s;

  // attributes held in an enclave control page
  typedef struct packed {
    logic        initialized;
    logic [63:0] enclave_base;
    logic [63:0] enclave_size;
    logic [63:0] control_id;
  } ctrl_attr_s;
endpackage : augment_pkg

// *** hdl/enclave_page_augment.sv ***
// page augment leaf unit: checks one leaf issue, zeroes the page, writes map
// assumes same-clock lock manager, map/attr read of one cycle latency,
// page and map write ports with ready, apb master on core_clk
//
// Behaviour
// - leaf code 0dh selects this operation
// - refuse unless privilege level is zero
// - descriptor address not 32-byte aligned: gp
// - destination not 4 KiB aligned: gp
// - destination outside page cache: pf
// - control pointer or linear address misaligned: gp
// - source or security field nonzero: gp
// - control page invalid or wrong type: pf
// - destination held by another: gp
// - control page conflicting holder: gp
// - destination entry already valid: pf
// - enclave not initialized: gp
// - linear address outside enclave range: gp
// - clear all destination page bits
// - entry read write, no exec, regular
// - pending set, other flags cleared
// - store linear address and control id
// - valid bit written last
// - segment limit or noncanonical operand: gp
// - locked memory operand: gp
//
// Local design decisions: register access over APB and the register addresses.
`timescale 1ns/100ps
`include "augment_consts.svh"
module enclave_page_augment (
  input  wire logic                   core_clk,
  input  wire logic                   rst_n,
  input  wire logic                   ce,
  input  wire logic                   req_valid,
  output logic                        req_ready,
  input  wire augment_pkg::leaf_req_s req,
  output logic                        rsp_valid,
  output augment_pkg::leaf_rsp_s      rsp,
  output logic                        lock_req,
  output logic [63:0]                 lock_addr,
  output logic                        lock_excl,
  input  wire logic                   lock_grant,
  output logic                        lock_release,
  output logic                        meta_rd,
  output logic [63:0]                 meta_addr,
  input  wire augment_pkg::map_entry_s meta_entry,
  input  wire augment_pkg::ctrl_attr_s meta_attr,
  output logic                        pg_wr_valid,
  input  wire logic                   pg_wr_ready,
  output logic [63:0]                 pg_wr_addr,
  output logic [31:0]                 pg_wr_data,
  output logic                        map_wr_valid,
  input  wire logic                   map_wr_ready,
  output logic [63:0]                 map_wr_addr,
  output augment_pkg::map_entry_s     map_wr_entry,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [11:0]            paddr,
  input  wire logic [31:0]            pwdata,
  output logic                        pready,
  output logic [31:0]                 prdata,
  output logic                        pslverr
);
  typedef enum logic [2:0] {
    S_IDLE, S_LOCK_DST, S_DST_CHK, S_LOCK_CTL, S_CTL_CHK,
    S_CLEAR, S_MAP, S_VALID
  } state_e;

  state_e                  state;
  augment_pkg::leaf_req_s  held;
  logic [9:0]              word_cnt;
  logic [31:0]             ctrl;
  logic [31:0]             cache_base;
  logic [31:0]             cache_pages;
  logic [15:0]             done_cnt;
  logic [1:0]              last_kind;
  logic [63:0]             last_addr;

  // low bits below lsb are zero
  function automatic logic aligned(input logic [63:0] a, input int lsb);
    logic [63:0] m;
    m = (64'h1 << lsb) - 64'h1;
    return (a & m) == 64'h0;
  endfunction : aligned

  // address falls on a page inside the configured cache window
  function automatic logic in_cache(input logic [63:0] a,
                                    input logic [31:0] base,
                                    input logic [31:0] pages);
    logic [31:0] pn;
    logic [31:0] rel;
    pn  = a[`AUG_PAGE_NUM_MSB:`AUG_PAGE_LSB];
    rel = pn - base;
    return (a[63:`AUG_PAGE_NUM_MSB+1] == 20'h0) && (pn >= base)
           && (rel < pages);
  endfunction : in_cache

  // request handshake and immediate checks in issue order
  wire take     = req_valid && req_ready;
  wire leaf_ok  = req.accumulator_register == `AUG_LEAF_CODE;
  wire cpl_bad  = req.cpl != `AUG_CPL_REQUIRED;
  wire desc_bad = !aligned(req.second_operand_register,
                           `AUG_DESC_ALIGN_LSB);
  wire dst_bad  = !aligned(req.third_operand_register,
                           `AUG_PAGE_LSB);
  wire dst_out  = !in_cache(req.third_operand_register,
                            cache_base, cache_pages);
  wire ptr_bad  = !aligned(req.control_page_ptr, `AUG_PAGE_LSB)
                  || !aligned(req.target_linear_address,
                              `AUG_PAGE_LSB);
  wire zero_bad = (req.source_page_field != 64'h0)
                  || (req.security_info_field != 64'h0);
  wire ctl_out  = !in_cache(req.control_page_ptr,
                            cache_base, cache_pages);
  wire gp_early = cpl_bad || req.segment_violation
                  || req.operand_locked
                  || desc_bad || dst_bad;
  wire gp_late  = ptr_bad || zero_bad;

  // control page checks once its entry and attributes return
  wire ctl_type_bad = !meta_entry.valid
                      || meta_entry.page_type != `AUG_PT_CONTROL;
  wire [64:0] ctl_end = {1'b0, meta_attr.enclave_base}
                        + {1'b0, meta_attr.enclave_size};
  wire range_bad = ({1'b0, held.target_linear_address}
                    < {1'b0, meta_attr.enclave_base})
                   || ({1'b0, held.target_linear_address}
                       >= ctl_end);

  // handshake outputs
  assign req_ready = ce && state == S_IDLE && ctrl[`AUG_CTRL_ENABLE];
  assign lock_req  = ce && (state == S_LOCK_DST || state == S_LOCK_CTL);
  assign meta_rd   = lock_req && lock_grant;
  assign lock_addr = meta_addr;
  assign pg_wr_valid  = ce && state == S_CLEAR;
  assign map_wr_valid = ce && (state == S_MAP || state == S_VALID);
  assign pg_wr_data   = 32'h0;
  assign pg_wr_addr   = held.third_operand_register
                        + {52'h0, word_cnt, 2'h0};
  assign map_wr_addr  = held.third_operand_register;

  // leaf sequencer
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state        <= S_IDLE;
      held         <= '0;
      word_cnt     <= 10'h0;
      rsp_valid    <= 1'b0;
      rsp          <= '0;
      lock_release <= 1'b0;
      lock_excl    <= 1'b0;
      meta_addr    <= 64'h0;
      map_wr_entry <= '0;
    end else if (ce) begin
      rsp_valid    <= 1'b0;
      lock_release <= 1'b0;
      case (state)
        S_IDLE: begin
          if (take) begin
            held      <= req;
            meta_addr <= req.third_operand_register;
            lock_excl <= 1'b1;
            word_cnt  <= 10'h0;
            rsp_valid <= !leaf_ok || gp_early || dst_out
                         || gp_late || ctl_out;
            rsp.addr  <= 64'h0;
            if (!leaf_ok)
              rsp.kind <= augment_pkg::FAULT_LEAF;
            else if (gp_early)
              rsp.kind <= augment_pkg::FAULT_GP;
            else if (dst_out) begin
              rsp.kind <= augment_pkg::FAULT_PF;
              rsp.addr <= req.third_operand_register;
            end else if (gp_late)
              rsp.kind <= augment_pkg::FAULT_GP;
            else if (ctl_out) begin
              rsp.kind <= augment_pkg::FAULT_PF;
              rsp.addr <= req.control_page_ptr;
            end else
              state <= S_LOCK_DST;
          end
        end
        S_LOCK_DST: begin
          if (!lock_grant) begin
            rsp_valid    <= 1'b1;
            rsp          <= '{augment_pkg::FAULT_GP, 64'h0};
            lock_release <= 1'b1;
            state        <= S_IDLE;
          end else
            state <= S_DST_CHK;
        end
        S_DST_CHK: begin
          meta_addr <= held.control_page_ptr;
          lock_excl <= 1'b0;
          if (meta_entry.valid) begin
            rsp_valid    <= 1'b1;
            rsp          <= '{augment_pkg::FAULT_PF,
                              held.third_operand_register};
            lock_release <= 1'b1;
            state        <= S_IDLE;
          end else
            state <= S_LOCK_CTL;
        end
        S_LOCK_CTL: begin
          if (!lock_grant) begin
            rsp_valid    <= 1'b1;
            rsp          <= '{augment_pkg::FAULT_GP, 64'h0};
            lock_release <= 1'b1;
            state        <= S_IDLE;
          end else
            state <= S_CTL_CHK;
        end
        S_CTL_CHK: begin
          rsp.addr <= 64'h0;
          if (ctl_type_bad || !meta_attr.initialized || range_bad) begin
            rsp_valid    <= 1'b1;
            lock_release <= 1'b1;
            state        <= S_IDLE;
            if (ctl_type_bad) begin
              rsp.kind <= augment_pkg::FAULT_PF;
              rsp.addr <= held.control_page_ptr;
            end else
              rsp.kind <= augment_pkg::FAULT_GP;
          end else begin
            map_wr_entry <= '{valid: 1'b0, read_en: 1'b1,
                              write_en: 1'b1, exec_en: 1'b0,
                              page_type: `AUG_PT_REGULAR,
                              blocked: 1'b0, pending: 1'b1,
                              flag_a: 1'b0,
                              permission_restrict_flag: 1'b0,
                              entry_linear_address:
                                held.target_linear_address,
                              control_id: meta_attr.control_id};
            state <= S_CLEAR;
          end
        end
        S_CLEAR: begin
          if (pg_wr_ready) begin
            word_cnt <= word_cnt + 10'h1;
            if (word_cnt == 10'h3ff)
              state <= S_MAP;
          end
        end
        S_MAP: begin
          if (map_wr_ready) begin
            map_wr_entry.valid <= 1'b1;
            state              <= S_VALID;
          end
        end
        S_VALID: begin
          if (map_wr_ready) begin
            rsp_valid    <= 1'b1;
            rsp          <= '{augment_pkg::FAULT_NONE, 64'h0};
            lock_release <= 1'b1;
            state        <= S_IDLE;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // apb decode; slave always answers in the access cycle
  wire apb_wr = psel && penable && pwrite;
  wire hit_ctrl = paddr == `AUG_OFF_CTRL;
  wire hit_base = paddr == `AUG_OFF_CACHE_BASE;
  wire hit_pgs  = paddr == `AUG_OFF_CACHE_PGS;
  wire hit_stat = paddr == `AUG_OFF_STATUS;
  wire hit_flo  = paddr == `AUG_OFF_FAULT_LO;
  wire hit_fhi  = paddr == `AUG_OFF_FAULT_HI;
  wire hit_any  = hit_ctrl || hit_base || hit_pgs || hit_stat
                  || hit_flo || hit_fhi;
  wire [31:0] status_word = {done_cnt, 12'h0, last_kind, 1'b0,
                             state != S_IDLE};
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit_any;
  assign prdata  = !(psel && penable && !pwrite) ? 32'h0 :
                   hit_ctrl ? ctrl :
                   hit_base ? cache_base :
                   hit_pgs  ? cache_pages :
                   hit_stat ? status_word :
                   hit_flo  ? last_addr[31:0] :
                   hit_fhi  ? last_addr[63:32] : 32'h0;

  // writable configuration
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ctrl        <= `AUG_CTRL_RESET;
      cache_base  <= 32'h0;
      cache_pages <= 32'h0;
    end else if (ce && apb_wr) begin
      if (hit_ctrl)
        ctrl <= pwdata;
      if (hit_base)
        cache_base <= pwdata;
      if (hit_pgs)
        cache_pages <= pwdata;
    end
  end

  // result history seen by software
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      done_cnt  <= 16'h0;
      last_kind <= 2'h0;
      last_addr <= 64'h0;
    end else if (ce && rsp_valid) begin
      done_cnt  <= done_cnt + 16'h1;
      last_kind <= rsp.kind;
      last_addr <= rsp.addr;
    end
  end

  // helper state for the checks below
  logic       fields_done;
  logic [1:0] map_writes;
  logic [10:0] clr_writes;
  always_ff @(posedge core_clk) begin
    if (!rst_n || take) begin
      fields_done <= 1'b0;
      map_writes  <= 2'h0;
      clr_writes  <= 11'h0;
    end else if (ce) begin
      if (map_wr_valid && map_wr_ready) begin
        fields_done <= 1'b1;
        map_writes  <= map_writes + 2'h1;
      end
      if (pg_wr_valid && pg_wr_ready)
        clr_writes <= clr_writes + 11'h1;
    end
  end

  property p_leaf_only;
    @(posedge core_clk) disable iff (!rst_n)
    ce && take && !leaf_ok |=> rsp_valid
      && rsp.kind == augment_pkg::FAULT_LEAF && state == S_IDLE;
  endproperty
  a_leaf_only: assert property (p_leaf_only)
    else $error("wrong leaf code was not refused");

  property p_cpl;
    @(posedge core_clk) disable iff (!rst_n)
    ce && take && leaf_ok && cpl_bad |=> rsp_valid
      && rsp.kind == augment_pkg::FAULT_GP;
  endproperty
  a_cpl: assert property (p_cpl)
    else $error("nonzero privilege did not fault");

  property p_dest_pf;
    @(posedge core_clk) disable iff (!rst_n)
    ce && take && leaf_ok && !gp_early && dst_out |=> rsp_valid
      && rsp.kind == augment_pkg::FAULT_PF
      && rsp.addr == $past(req.third_operand_register);
  endproperty
  a_dest_pf: assert property (p_dest_pf)
    else $error("destination outside cache did not page fault");

  property p_dest_lock;
    @(posedge core_clk) disable iff (!rst_n)
    ce && state == S_LOCK_DST && !lock_grant ##1 ce |-> rsp_valid
      && rsp.kind == augment_pkg::FAULT_GP && lock_release;
  endproperty
  a_dest_lock: assert property (p_dest_lock)
    else $error("refused destination lock did not fault");

  property p_entry_fields;
    @(posedge core_clk) disable iff (!rst_n)
    map_wr_valid |-> map_wr_entry.read_en && map_wr_entry.write_en
      && !map_wr_entry.exec_en
      && map_wr_entry.page_type == `AUG_PT_REGULAR
      && map_wr_entry.pending && !map_wr_entry.blocked
      && !map_wr_entry.flag_a && !map_wr_entry.permission_restrict_flag;
  endproperty
  a_entry_fields: assert property (p_entry_fields)
    else $error("map entry fields wrong");

  property p_lin_recorded;
    @(posedge core_clk) disable iff (!rst_n)
    map_wr_valid |-> map_wr_entry.entry_linear_address
      == held.target_linear_address;
  endproperty
  a_lin_recorded: assert property (p_lin_recorded)
    else $error("linear address not stored in entry");

  property p_valid_last;
    @(posedge core_clk) disable iff (!rst_n)
    map_wr_valid && map_wr_entry.valid |-> fields_done
      && clr_writes == `AUG_PAGE_WORDS;
  endproperty
  a_valid_last: assert property (p_valid_last)
    else $error("valid bit written before fields and clear");

  property p_no_change_on_fault;
    @(posedge core_clk) disable iff (!rst_n)
    rsp_valid && rsp.kind != augment_pkg::FAULT_NONE |->
      map_writes == 2'h0 && clr_writes == 11'h0;
  endproperty
  a_no_change_on_fault: assert property (p_no_change_on_fault)
    else $error("page or map changed on a faulting leaf");

  property p_ok_complete;
    @(posedge core_clk) disable iff (!rst_n)
    rsp_valid && rsp.kind == augment_pkg::FAULT_NONE |->
      map_writes == 2'h2 && clr_writes == `AUG_PAGE_WORDS;
  endproperty
  a_ok_complete: assert property (p_ok_complete)
    else $error("success without full clear and two map writes");
endmodule : enclave_page_augment

// *** testbench/mem_side_model.sv ***
// far side of the leaf unit: lock manager, map reads, page and map writes
// assumes the unit on the same clock; bench sets the knobs between leaves
`timescale 1ns/100ps
module mem_side_model (
  input  wire logic                    core_clk,
  input  wire logic                    clr,
  input  wire logic                    slow,
  input  wire logic                    deny_excl,
  input  wire logic                    deny_shared,
  input  wire logic [63:0]             dest,
  input  wire augment_pkg::map_entry_s dest_entry,
  input  wire augment_pkg::map_entry_s ctrl_entry,
  input  wire augment_pkg::ctrl_attr_s attr,
  input  wire logic                    lock_req,
  input  wire logic                    lock_excl,
  output logic                         lock_grant,
  input  wire logic                    meta_rd,
  input  wire logic [63:0]             meta_addr,
  output augment_pkg::map_entry_s      meta_entry,
  output augment_pkg::ctrl_attr_s      meta_attr,
  input  wire logic                    pg_wr_valid,
  output logic                         pg_wr_ready,
  input  wire logic [63:0]             pg_wr_addr,
  input  wire logic [31:0]             pg_wr_data,
  input  wire logic                    map_wr_valid,
  output logic                         map_wr_ready,
  input  wire logic [63:0]             map_wr_addr,
  input  wire augment_pkg::map_entry_s map_wr_entry,
  output int                           pg_cnt,
  output int                           wr_bad,
  output int                           map_cnt,
  output augment_pkg::map_entry_s      map_first,
  output augment_pkg::map_entry_s      map_last
);
  logic toggle = 1'b0;

  // grant at once unless the bench plays a conflicting holder
  assign lock_grant   = lock_req & !(lock_excl ? deny_excl : deny_shared);
  assign pg_wr_ready  = !slow | toggle;
  assign map_wr_ready = !slow | toggle;

  // metadata one cycle after the read, scrambled otherwise; count writes
  always @(posedge core_clk) begin
    toggle <= ~toggle;
    if (meta_rd) begin
      meta_entry <= (meta_addr == dest) ? dest_entry : ctrl_entry;
      meta_attr  <= attr;
    end else begin
      meta_entry <= ~meta_entry;
      meta_attr  <= ~meta_attr;
    end
    if (clr) begin
      pg_cnt  <= 0;
      wr_bad  <= 0;
      map_cnt <= 0;
    end else begin
      if (pg_wr_valid && pg_wr_ready) begin
        pg_cnt <= pg_cnt + 1;
        if (pg_wr_data !== 32'h0 || pg_wr_addr !== dest + 64'(4 * pg_cnt))
          wr_bad <= wr_bad + 1;
      end
      if (map_wr_valid && map_wr_ready) begin
        map_cnt  <= map_cnt + 1;
        map_last <= map_wr_entry;
        if (map_cnt == 0)
          map_first <= map_wr_entry;
        if (map_wr_addr !== dest)
          wr_bad <= wr_bad + 1;
      end
    end
  end
endmodule : mem_side_model

// *** testbench/tb_enclave_page_augment.sv ***
// self-checking bench for the page augment leaf unit
// assumes the memory side model and apb access to the control registers
`timescale 1ns/100ps
module tb_enclave_page_augment;
  logic core_clk = 1'b0, rst_n = 1'b0, ce = 1'b1, req_valid = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, clr = 1'b0;
  logic slow = 1'b0, deny_excl = 1'b0, deny_shared = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic [63:0] dest = 64'h0, meta_addr, pg_wr_addr, map_wr_addr, lock_addr;
  logic req_ready, rsp_valid, lock_req, lock_excl, lock_grant, meta_rd;
  logic pg_wr_valid, pg_wr_ready, map_wr_valid, map_wr_ready;
  logic pready, pslverr, e, lock_release;
  logic [31:0] pg_wr_data;
  augment_pkg::leaf_req_s  req = '0, r;
  augment_pkg::leaf_rsp_s  rsp;
  augment_pkg::map_entry_s meta_entry, map_wr_entry, map_first, map_last;
  augment_pkg::map_entry_s dest_entry = '0, ctrl_entry = '0, x;
  augment_pkg::ctrl_attr_s meta_attr, attr = '0;
  int pg_cnt, wr_bad, map_cnt, checks = 0, miscompares = 0, seed, rnd;

  always #50 core_clk = ~core_clk;

  enclave_page_augment i_enclave_page_augment (.*);
  mem_side_model i_mem_side_model (.*);

  task automatic check(input bit ok, input string msg);
    checks++;
    if (!ok) begin
      miscompares++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask : check

  task automatic complete_run;
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : complete_run

  // one apb transfer, entered just after a rising edge
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge core_clk) penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask : apb

  function automatic bit in_cache(input logic [63:0] a);
    return a[63:44] == 0 && a[43:12] >= 32'h100 && a[43:12] < 32'h110;
  endfunction : in_cache

  // expected result worked out from the checks in their order
  function automatic augment_pkg::leaf_rsp_s model(augment_pkg::leaf_req_s t);
    augment_pkg::leaf_rsp_s o;
    logic [63:0] l;
    l = t.target_linear_address;
    o = '{augment_pkg::FAULT_GP, 64'h0};
    if (t.accumulator_register != 32'hd) o.kind = augment_pkg::FAULT_LEAF;
    else if (t.cpl != 0 || t.segment_violation || t.operand_locked ||
             t.second_operand_register[4:0] != 0 ||
             t.third_operand_register[11:0] != 0) o.kind = augment_pkg::FAULT_GP;
    else if (!in_cache(t.third_operand_register))
      o = '{augment_pkg::FAULT_PF, t.third_operand_register};
    else if (t.control_page_ptr[11:0] != 0 || l[11:0] != 0 ||
             t.source_page_field != 0 || t.security_info_field != 0) o.kind = augment_pkg::FAULT_GP;
    else if (!in_cache(t.control_page_ptr))
      o = '{augment_pkg::FAULT_PF, t.control_page_ptr};
    else if (deny_excl) o.kind = augment_pkg::FAULT_GP;
    else if (dest_entry.valid)
      o = '{augment_pkg::FAULT_PF, t.third_operand_register};
    else if (deny_shared) o.kind = augment_pkg::FAULT_GP;
    else if (!ctrl_entry.valid || ctrl_entry.page_type != 8'h00)
      o = '{augment_pkg::FAULT_PF, t.control_page_ptr};
    else if (!attr.initialized) o.kind = augment_pkg::FAULT_GP;
    else if (l < attr.enclave_base || l >= attr.enclave_base + attr.enclave_size)
      o.kind = augment_pkg::FAULT_GP;
    else o.kind = augment_pkg::FAULT_NONE;
    return o;
  endfunction : model

  // issue one leaf, wait for its result and compare with the model
  task automatic run_leaf(input augment_pkg::leaf_req_s t);
    augment_pkg::leaf_rsp_s ex;
    ex = model(t);
    clr <= 1'b1;
    @(posedge core_clk);
    clr <= 1'b0; req <= t; req_valid <= 1'b1;
    do @(posedge core_clk); while (req_ready !== 1'b1);
    req_valid <= 1'b0;
    do @(negedge core_clk); while (rsp_valid !== 1'b1);
    check(rsp === ex, "leaf result differs");
    if (ex.kind == augment_pkg::FAULT_NONE) begin
      x = '{1'b1, 1'b1, 1'b1, 1'b0, 8'h01, 1'b0, 1'b1, 1'b0, 1'b0,
            t.target_linear_address, attr.control_id};
      check(pg_cnt == 1024 && wr_bad == 0, "page not cleared");
      check(map_cnt == 2 && map_first.valid === 1'b0, "valid early");
      check(map_last === x, "map entry differs");
      check(lock_release && lock_addr === t.control_page_ptr, "lock");
    end else
      check(pg_cnt == 0 && map_cnt == 0, "write on fault");
  endtask : run_leaf

  initial begin
    seed = 21663;
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    apb(1'b0, 12'h000, 32'h0);
    check(q === 32'h0 && e === 1'b0 && req_ready === 1'b0, "ctrl reset");
    apb(1'b1, 12'h004, 32'h100);
    apb(1'b1, 12'h008, 32'h10);
    ce <= 1'b0;
    apb(1'b1, 12'h008, 32'h7);
    ce <= 1'b1;
    apb(1'b0, 12'h008, 32'h0);
    check(q === 32'h10, "write landed while frozen");
    apb(1'b1, 12'h000, 32'h1);
    apb(1'b0, 12'h018, 32'h0);
    check(e === 1'b1 && q === 32'h0, "unmapped access");
    for (int i = 0; i < 18; i++) begin
      rnd = $random(seed);
      r = '0;
      r.accumulator_register = 32'hd;
      r.second_operand_register = 64'h2000_0040;
      r.third_operand_register = {20'h0, 32'h108 + 32'(rnd[2:0]), 12'h0};
      r.control_page_ptr = 64'h0010_1000;
      r.target_linear_address = 64'h4000_0000 + {rnd[7:4], 12'h0};
      dest = r.third_operand_register;
      dest_entry = '0;
      ctrl_entry = '0;
      ctrl_entry.valid = 1'b1;
      ctrl_entry.control_id = 64'h5a;
      attr = '{1'b1, 64'h4000_0000, 64'h1_0000, 64'h5a};
      deny_excl = 1'b0;
      deny_shared = 1'b0;
      slow <= rnd[8];
      case (i)
        1: r.accumulator_register = 32'hc;
        2: r.cpl = 2'h3;
        3: r.second_operand_register[4] = 1'b1;
        4: r.third_operand_register[11] = 1'b1;
        5: r.third_operand_register = 64'h0020_0000;
        6: r.control_page_ptr[6] = 1'b1;
        7: r.source_page_field = 64'h1;
        8: r.control_page_ptr = 64'h0011_0000;
        9: deny_excl = 1'b1;
        10: dest_entry.valid = 1'b1;
        11: deny_shared = 1'b1;
        12: ctrl_entry.page_type = 8'h01;
        13: attr.initialized = 1'b0;
        14: r.target_linear_address = 64'h4001_0000;
        15: r.segment_violation = 1'b1;
        16: r.operand_locked = 1'b1;
        17: r.security_info_field = 64'h40;
        default: ;
      endcase
      run_leaf(r);
    end
    @(posedge core_clk);
    apb(1'b0, 12'h00c, 32'h0);
    check(q[31:16] === 16'h12 && q[3:2] === 2'h1, "status");
    complete_run;
  end

  // cut a hang short
  initial begin
    repeat (20000) @(posedge core_clk);
    miscompares++;
    complete_run;
  end
endmodule : tb_enclave_page_augment
